// ### hdl/seb_pkg.sv
// Constants shared by the serial memory bus front end.
// Assumes a 250 MHz core clock and bus pins that are already resolved levels.
package seb_pkg;

  // Core clock period and write cycle time.
  localparam int CLK_PERIOD_NS = 4;
  localparam int T_WRITE_NS = 5000000;
  localparam int WRITE_CYCLES = T_WRITE_NS / CLK_PERIOD_NS;
  localparam int WR_CNT_W = 21;

  // Select byte layout, sent most significant bit first.
  localparam int SEL_RW_BIT = 0;
  localparam int SEL_CE_LSB = 1;
  localparam int SEL_ID_LSB = 4;
  localparam int SEL_ID_MSB = 7;

  // Bit counting: eight data bits then the acknowledge bit.
  localparam int BIT_CNT_W = 4;
  localparam logic [3:0] BIT_LAST_DATA = 4'h7;
  localparam logic [3:0] BIT_ACK = 4'h8;
  localparam logic [3:0] BIT_AFTER_ACK = 4'h1;
  localparam logic [1:0] BYTES_FOR_WRITE = 2'h2;

  // Reset values of the synchronised pins: lines idle high, power low.
  localparam logic [7:0] PIN_RST_VAL = 8'he0;

  typedef enum logic [2:0] {
    ST_STANDBY = 3'b000,
    ST_SELECT = 3'b001,
    ST_ACK = 3'b010,
    ST_ACTIVE = 3'b011,
    ST_WRITE = 3'b100
  } seb_state_t;

endpackage : seb_pkg

// ### hdl/seb_sync.sv
// Three-stage synchroniser for levels entering the core clock domain.
// Assumes each bit is a slow level; the output moves once stages two
// and three agree, so a single metastable sample never gets through.
`timescale 1ns/100ps
module seb_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_rst_b,
  // Asynchronous input and its synchronised copy.
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      s1_q <= RST_VAL;
      s2_q <= RST_VAL;
      s3_q <= RST_VAL;
    end else begin
      s1_q <= i_async;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_sync <= RST_VAL;
    end else begin
      for (int i = 0; i < W; i++) begin
        if (s2_q[i] == s3_q[i]) begin
          o_sync[i] <= s3_q[i];
        end
      end
    end
  end

endmodule : seb_sync

// ### hdl/seb_frontend.sv
// Bus front end of a two-wire serial memory slave: power gating, Start and
// Stop detection, select byte decode, select acknowledge and write cycle.
// Assumes the serial clock pin also feeds I_SCL as a clock, and that the
// master changes data only while the serial clock is low.
`timescale 1ns/100ps
// Behaviour
// - While power is not yet good the bus is ignored and data released.
// - When power becomes good the logic resets and waits in standby.
// - When power drops out the device stops answering the bus at once.
// - A Stop outside a write cycle that does not close a write command sends the device to standby.
// - The select byte arrives MSB first and its top four bits must match.
// - In base capacity select bits three to one compare with the straps.
// - Larger capacities take select bits from one upward as address 8 upward, one bit per doubling.
// - Select bit zero set means read, clear means write.
// - A select byte that does not match gets no acknowledge and standby.
// - The device is only a slave clocked by the master's serial clock.
// - Start is data falling while the serial clock stays high.
// - Starts are watched for whenever power is good, except during a write cycle.
// - Stop is data rising while the serial clock is high; it ends a talk.
// - A Stop after a read ended with no acknowledge gives standby.
// - A Stop closing a write command starts the silent write cycle.
module seb_frontend #(
  parameter logic [3:0] DEV_TYPE_ID = 4'h6,
  parameter int unsigned WRITE_CYCLES = seb_pkg::WRITE_CYCLES
) (
  // Core clock and reset.
  input wire logic I_CLK,
  input wire logic I_RST_B,
  // Power-on reset condition, high while supply is below threshold.
  input wire logic I_POR,
  // Serial bus; the clock pin is also the link clock.
  input wire logic I_SCL,
  input wire logic I_SDA_I,
  output logic O_SDA_O,
  output logic O_SDA_OE_B,
  // Straps and capacity code (0 base, 1 double, 2 quad, 3 eightfold).
  input wire logic I_STRAP_SELECT_BIT0,
  input wire logic I_STRAP_SELECT_BIT1,
  input wire logic I_STRAP_SELECT_BIT2,
  input wire logic [1:0] I_CAPACITY,
  // Status toward the memory core.
  output logic O_STANDBY,
  output logic O_SELECTED,
  output logic O_READ_DIR,
  output logic O_WRITE_BUSY,
  output logic O_MEM_ADDR_BIT_EIGHT,
  output logic O_MEM_ADDR_BIT_NINE,
  output logic O_MEM_ADDR_BIT_TEN
);

  // The value of DEV_TYPE_ID is arbitrary and must be set per product.

  // Link domain: bits are taken on the master's rising clock edge.
  logic [7:0] link_sreg_q;
  logic link_tog_q;

  always_ff @(posedge I_SCL or negedge I_RST_B) begin
    if (!I_RST_B) begin
      link_sreg_q <= 8'h00;
      link_tog_q <= 1'b0;
    end else begin
      link_sreg_q <= {link_sreg_q[6:0], I_SDA_I};
      link_tog_q <= ~link_tog_q;
    end
  end

  // Pin synchronisers.
  logic [7:0] pins_s;
  logic tog_s;
  logic sda_s;
  logic scl_s;
  logic por_s;
  logic [2:0] strap_s;
  logic [1:0] cap_s;

  seb_sync #(.W(8), .RST_VAL(seb_pkg::PIN_RST_VAL)) u_pin_sync (
    .i_clk(I_CLK),
    .i_rst_b(I_RST_B),
    .i_async({I_SDA_I, I_SCL, I_POR, I_STRAP_SELECT_BIT2,
              I_STRAP_SELECT_BIT1, I_STRAP_SELECT_BIT0, I_CAPACITY}),
    .o_sync(pins_s)
  );

  // The toggle marks a fresh bit; the shift register is then stable for
  // most of a serial clock period, which is what makes reading it safe.
  seb_sync #(.W(1), .RST_VAL(1'b0)) u_tog_sync (
    .i_clk(I_CLK),
    .i_rst_b(I_RST_B),
    .i_async(link_tog_q),
    .o_sync(tog_s)
  );

  assign sda_s = pins_s[7];
  assign scl_s = pins_s[6];
  assign por_s = pins_s[5];
  assign strap_s = pins_s[4:2];
  assign cap_s = pins_s[1:0];

  function automatic logic sel_match(input logic [7:0] sel,
                                     input logic [3:0] id,
                                     input logic [2:0] strap,
                                     input logic [1:0] cap);
    logic ok;
    ok = (sel[seb_pkg::SEL_ID_MSB:seb_pkg::SEL_ID_LSB] == id);
    for (int i = 0; i < 3; i++) begin
      if (i >= int'(cap) && sel[seb_pkg::SEL_CE_LSB + i] != strap[i]) begin
        ok = 1'b0;
      end
    end
    return ok;
  endfunction : sel_match

  function automatic logic [2:0] sel_addr(input logic [7:0] sel,
                                          input logic [1:0] cap);
    logic [2:0] a;
    a = 3'h0;
    for (int i = 0; i < 3; i++) begin
      if (i < int'(cap)) begin
        a[i] = sel[seb_pkg::SEL_CE_LSB + i];
      end
    end
    return a;
  endfunction : sel_addr

  // Edge history in the core domain.
  logic sda_prev_q;
  logic scl_prev_q;
  logic tog_seen_q;

  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      sda_prev_q <= 1'b1;
      scl_prev_q <= 1'b1;
      tog_seen_q <= 1'b0;
    end else begin
      sda_prev_q <= sda_s;
      scl_prev_q <= scl_s;
      tog_seen_q <= tog_s;
    end
  end

  logic start_evt;
  logic stop_evt;
  logic bit_evt;
  logic scl_fall;
  logic byte_ok;

  assign start_evt = scl_s && scl_prev_q && sda_prev_q && !sda_s;
  assign stop_evt = scl_s && scl_prev_q && !sda_prev_q && sda_s;
  assign bit_evt = (tog_s != tog_seen_q);
  assign scl_fall = scl_prev_q && !scl_s;
  assign byte_ok = sel_match(link_sreg_q, DEV_TYPE_ID, strap_s, cap_s);

  // Main state machine.
  seb_pkg::seb_state_t state_q;
  seb_pkg::seb_state_t state_d;
  logic [seb_pkg::BIT_CNT_W-1:0] bit_cnt_q;
  logic [1:0] byte_cnt_q;
  logic ack_on_q;
  logic read_q;
  logic [seb_pkg::WR_CNT_W-1:0] wr_cnt_q;
  logic write_ok;

  assign write_ok = !read_q && (byte_cnt_q >= seb_pkg::BYTES_FOR_WRITE)
                    && (bit_cnt_q == seb_pkg::BIT_AFTER_ACK);

  always_comb begin
    state_d = state_q;
    if (por_s) begin
      state_d = seb_pkg::ST_STANDBY;
    end else begin
      unique case (state_q)
        seb_pkg::ST_STANDBY: begin
          if (start_evt) state_d = seb_pkg::ST_SELECT;
        end
        seb_pkg::ST_SELECT: begin
          if (start_evt) begin
            state_d = seb_pkg::ST_SELECT;
          end else if (stop_evt) begin
            state_d = seb_pkg::ST_STANDBY;
          end else if (bit_evt && bit_cnt_q == seb_pkg::BIT_LAST_DATA) begin
            if (byte_ok) state_d = seb_pkg::ST_ACK;
            else state_d = seb_pkg::ST_STANDBY;
          end
        end
        seb_pkg::ST_ACK: begin
          if (start_evt) state_d = seb_pkg::ST_SELECT;
          else if (stop_evt) state_d = seb_pkg::ST_STANDBY;
          else if (scl_fall && ack_on_q) state_d = seb_pkg::ST_ACTIVE;
        end
        seb_pkg::ST_ACTIVE: begin
          if (start_evt) begin
            state_d = seb_pkg::ST_SELECT;
          end else if (stop_evt) begin
            if (write_ok) state_d = seb_pkg::ST_WRITE;
            else state_d = seb_pkg::ST_STANDBY;
          end
        end
        seb_pkg::ST_WRITE: begin
          // Bus is ignored until the cycle ends.
          if (wr_cnt_q == '0) state_d = seb_pkg::ST_STANDBY;
        end
        default: state_d = seb_pkg::ST_STANDBY;
      endcase
    end
  end

  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) state_q <= seb_pkg::ST_STANDBY;
    else state_q <= state_d;
  end

  // Bit position within the current byte; the ninth is the acknowledge.
  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      bit_cnt_q <= '0;
    end else if (state_d == seb_pkg::ST_SELECT && start_evt) begin
      bit_cnt_q <= '0;
    end else if (state_q == seb_pkg::ST_ACK) begin
      bit_cnt_q <= '0;
    end else if (bit_evt && state_q == seb_pkg::ST_SELECT) begin
      bit_cnt_q <= bit_cnt_q + 4'h1;
    end else if (bit_evt && state_q == seb_pkg::ST_ACTIVE) begin
      if (bit_cnt_q == seb_pkg::BIT_ACK) bit_cnt_q <= '0;
      else bit_cnt_q <= bit_cnt_q + 4'h1;
    end
  end

  // Whole bytes seen after the select byte, saturating at two.
  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      byte_cnt_q <= 2'h0;
    end else if (state_q != seb_pkg::ST_ACTIVE) begin
      byte_cnt_q <= 2'h0;
    end else if (bit_evt && bit_cnt_q == seb_pkg::BIT_LAST_DATA
                 && byte_cnt_q != seb_pkg::BYTES_FOR_WRITE) begin
      byte_cnt_q <= byte_cnt_q + 2'h1;
    end
  end

  // Data is pulled low from the fall after bit eight to the fall after
  // bit nine, so it never moves while the serial clock is high.
  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) ack_on_q <= 1'b0;
    else if (state_q != seb_pkg::ST_ACK) ack_on_q <= 1'b0;
    else if (scl_fall) ack_on_q <= 1'b1;
  end

  // Direction and upper address captured from a matching select byte.
  logic [2:0] addr_hi_q;

  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      read_q <= 1'b0;
      addr_hi_q <= 3'h0;
    end else if (por_s) begin
      read_q <= 1'b0;
      addr_hi_q <= 3'h0;
    end else if (state_q == seb_pkg::ST_SELECT
                 && state_d == seb_pkg::ST_ACK) begin
      read_q <= link_sreg_q[seb_pkg::SEL_RW_BIT];
      addr_hi_q <= sel_addr(link_sreg_q, cap_s);
    end
  end

  // Write cycle timer.
  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      wr_cnt_q <= '0;
    end else if (state_q != seb_pkg::ST_WRITE
                 && state_d == seb_pkg::ST_WRITE) begin
      wr_cnt_q <= seb_pkg::WR_CNT_W'(WRITE_CYCLES - 1);
    end else if (state_q == seb_pkg::ST_WRITE && wr_cnt_q != '0) begin
      wr_cnt_q <= wr_cnt_q - 1'b1;
    end
  end

  // Registered outputs.
  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      O_SDA_O <= 1'b0;
      O_SDA_OE_B <= 1'b1;
    end else begin
      O_SDA_O <= 1'b0;
      O_SDA_OE_B <= !(state_d == seb_pkg::ST_ACK && !por_s
                      && (ack_on_q || scl_fall));
    end
  end

  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      O_STANDBY <= 1'b1;
      O_SELECTED <= 1'b0;
      O_WRITE_BUSY <= 1'b0;
    end else begin
      O_STANDBY <= (state_d == seb_pkg::ST_STANDBY);
      O_SELECTED <= (state_d == seb_pkg::ST_ACK)
                    || (state_d == seb_pkg::ST_ACTIVE);
      O_WRITE_BUSY <= (state_d == seb_pkg::ST_WRITE);
    end
  end

  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      O_READ_DIR <= 1'b0;
      O_MEM_ADDR_BIT_EIGHT <= 1'b0;
      O_MEM_ADDR_BIT_NINE <= 1'b0;
      O_MEM_ADDR_BIT_TEN <= 1'b0;
    end else begin
      O_READ_DIR <= read_q;
      O_MEM_ADDR_BIT_EIGHT <= addr_hi_q[0];
      O_MEM_ADDR_BIT_NINE <= addr_hi_q[1];
      O_MEM_ADDR_BIT_TEN <= addr_hi_q[2];
    end
  end

  // Checks.
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RST_B);

  property p_por_quiet;
    por_s |=> (state_q == seb_pkg::ST_STANDBY) && O_SDA_OE_B && O_STANDBY;
  endproperty
  a_por_quiet: assert property (p_por_quiet)
    else $error("bus not quiet under power reset");

  property p_por_release;
    $fell(por_s) |-> state_q == seb_pkg::ST_STANDBY;
  endproperty
  a_por_release: assert property (p_por_release)
    else $error("not in standby when power became good");

  property p_por_drop;
    (state_q == seb_pkg::ST_ACTIVE) && $rose(por_s)
      |=> !O_SELECTED ##1 !O_SELECTED;
  endproperty
  a_por_drop: assert property (p_por_drop)
    else $error("still selected after power dropped");

  property p_stop_standby;
    !por_s && state_q == seb_pkg::ST_ACTIVE && stop_evt && !write_ok
      |=> O_STANDBY && !O_WRITE_BUSY;
  endproperty
  a_stop_standby: assert property (p_stop_standby)
    else $error("stop did not give standby");

  property p_id_mismatch;
    !por_s && !start_evt && !stop_evt && state_q == seb_pkg::ST_SELECT
      && bit_evt && bit_cnt_q == seb_pkg::BIT_LAST_DATA
      && link_sreg_q[7:4] != DEV_TYPE_ID |=> O_STANDBY [*2];
  endproperty
  a_id_mismatch: assert property (p_id_mismatch)
    else $error("wrong type identifier was accepted");

  property p_match_capture;
    state_q == seb_pkg::ST_SELECT && state_d == seb_pkg::ST_ACK
      |-> ##2 O_READ_DIR == $past(link_sreg_q[0], 2)
      && O_MEM_ADDR_BIT_EIGHT == ($past(cap_s, 2) != 2'h0
                                  && $past(link_sreg_q[1], 2));
  endproperty
  a_match_capture: assert property (p_match_capture)
    else $error("direction or address bit not captured");

  property p_no_ack_mismatch;
    state_q == seb_pkg::ST_SELECT && bit_evt && !byte_ok
      |=> O_SDA_OE_B [*4];
  endproperty
  a_no_ack_mismatch: assert property (p_no_ack_mismatch)
    else $error("mismatching select byte acknowledged");

  property p_drive_only_ack;
    !O_SDA_OE_B |-> $past(state_d) == seb_pkg::ST_ACK && O_SDA_O == 1'b0;
  endproperty
  a_drive_only_ack: assert property (p_drive_only_ack)
    else $error("data driven outside acknowledge");

  property p_write_ignores;
    state_q == seb_pkg::ST_WRITE && !por_s && wr_cnt_q != '0
      |=> state_q == seb_pkg::ST_WRITE && O_SDA_OE_B;
  endproperty
  a_write_ignores: assert property (p_write_ignores)
    else $error("bus answered during write cycle");

  property p_write_start;
    !por_s && state_q == seb_pkg::ST_ACTIVE && stop_evt && write_ok
      |=> O_WRITE_BUSY ##1 wr_cnt_q == seb_pkg::WR_CNT_W'(WRITE_CYCLES - 2);
  endproperty
  a_write_start: assert property (p_write_start)
    else $error("write cycle not started by stop");

endmodule : seb_frontend

// ### bench/seb_master_model.sv
// Behavioural two-wire bus master that makes the serial clock and data.
// Assumes the bench resolves the open-drain data line with a pull-up.
`timescale 1ns/100ps
module seb_master_model (
  // Core clock, used only to set the link phase at each Start.
  input wire logic i_clk,
  // Serial clock, standing high between frames.
  output logic o_scl,
  // Data pull-down request, low pulls the line low.
  output logic o_sda_b,
  // Resolved data line.
  input wire logic i_sda
);
  initial begin
    o_scl = 1'b1;
    o_sda_b = 1'b1;
  end

  // The 1.3 ns offset keeps link edges away from core clock edges.
  task automatic start_cond();
    @(posedge i_clk);
    #11.3 o_sda_b = 1'b1;
    #30 o_scl = 1'b1;
    #40 o_sda_b = 1'b0;
    #40 o_scl = 1'b0;
  endtask : start_cond

  // Data moves only while the clock is low.
  task automatic bit_cycle(input logic b, output logic seen);
    #10 o_sda_b = b;
    #30 o_scl = 1'b1;
    #20 seen = i_sda;
    #20 o_scl = 1'b0;
  endtask : bit_cycle

  task automatic stop_cond();
    #10 o_sda_b = 1'b0;
    #30 o_scl = 1'b1;
    #40 o_sda_b = 1'b1;
    #40;
  endtask : stop_cond

  // Sends a byte most significant bit first; ack is high when pulled low.
  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_cycle(b[i], s);
    end
    bit_cycle(1'b1, s);
    ack = ~s;
  endtask : send_byte
endmodule : seb_master_model

// ### bench/tb_seb_frontend.sv
// Self-checking bench for the serial memory bus front end.
// Assumes the master model above; the data line has a pull-up.
`timescale 1ns/100ps
module tb_seb_frontend;
  // Arbitrary type identifier value.
  localparam logic [3:0] ID = 4'h9;
  localparam int WCYC = 400;
  logic clk, rst_b, por, scl, sda_b, sda_line, sda_o, sda_oe_b, ack;
  logic [2:0] strap;
  logic [1:0] cap;
  logic standby, selected, read_dir, write_busy, a8, a9, a10;
  int n_mismatch = 0;
  int total_checks = 0;

  assign sda_line = sda_b & (sda_oe_b | sda_o);

  seb_frontend #(.DEV_TYPE_ID(ID), .WRITE_CYCLES(WCYC)) seb_frontend_inst (
    .I_CLK(clk), .I_RST_B(rst_b), .I_POR(por), .I_SCL(scl),
    .I_SDA_I(sda_line), .O_SDA_O(sda_o), .O_SDA_OE_B(sda_oe_b),
    .I_STRAP_SELECT_BIT0(strap[0]), .I_STRAP_SELECT_BIT1(strap[1]),
    .I_STRAP_SELECT_BIT2(strap[2]), .I_CAPACITY(cap),
    .O_STANDBY(standby), .O_SELECTED(selected), .O_READ_DIR(read_dir),
    .O_WRITE_BUSY(write_busy), .O_MEM_ADDR_BIT_EIGHT(a8),
    .O_MEM_ADDR_BIT_NINE(a9), .O_MEM_ADDR_BIT_TEN(a10));

  seb_master_model seb_master_model_inst (
    .i_clk(clk), .o_scl(scl), .o_sda_b(sda_b), .i_sda(sda_line));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic settle(input int n);
    repeat (n) @(negedge clk);
  endtask : settle

  task automatic sel(input logic [7:0] b);
    seb_master_model_inst.start_cond();
    seb_master_model_inst.send_byte(b, ack);
  endtask : sel

  task automatic stop_settle();
    seb_master_model_inst.stop_cond();
    settle(8);
  endtask : stop_settle

  task automatic t_reset();
    check(standby, 1'b1);
    check(sda_oe_b, 1'b1);
    check({selected, write_busy}, 2'h0);
    $display("test reset done");
  endtask : t_reset

  // Bits used as address are flipped against the straps to show they
  // are no longer compared.
  task automatic t_capacity();
    logic [2:0] m, s;
    for (int c = 0; c < 4; c++) begin
      @(negedge clk);
      cap = c[1:0];
      settle(8);
      m = 3'((1 << c) - 1);
      s = strap ^ m;
      sel({ID, s, 1'b1});
      check(ack, 1'b1);
      settle(8);
      check({selected, read_dir}, 2'h3);
      check({a10, a9, a8}, s & m);
      stop_settle();
      check(standby, 1'b1);
    end
    @(negedge clk);
    cap = 2'h0;
    settle(8);
    $display("test capacity done");
  endtask : t_capacity

  task automatic t_mismatch();
    sel({~ID, strap, 1'b1});
    check(ack, 1'b0);
    check(standby, 1'b1);
    sel({ID, strap ^ 3'h4, 1'b0});
    check(ack, 1'b0);
    stop_settle();
    seb_master_model_inst.send_byte({ID, strap, 1'b1}, ack);
    check(ack, 1'b0);
    stop_settle();
    $display("test mismatch done");
  endtask : t_mismatch

  task automatic t_write();
    int n;
    sel({ID, strap, 1'b0});
    check(ack, 1'b1);
    settle(4);
    check(read_dir, 1'b0);
    seb_master_model_inst.send_byte(8'h10, ack);
    stop_settle();
    check({write_busy, standby}, 2'h1);
    // A repeated Start after an address byte turns the talk into a read.
    sel({ID, strap, 1'b0});
    seb_master_model_inst.send_byte(8'h20, ack);
    sel({ID, strap, 1'b1});
    check(ack, 1'b1);
    settle(4);
    check({selected, read_dir}, 2'h3);
    stop_settle();
    check({write_busy, standby}, 2'h1);
    sel({ID, strap, 1'b0});
    seb_master_model_inst.send_byte(8'h3c, ack);
    seb_master_model_inst.send_byte(8'ha5, ack);
    stop_settle();
    check({write_busy, selected}, 2'h2);
    sel({ID, strap, 1'b1});
    check(ack, 1'b0);
    check(write_busy, 1'b1);
    stop_settle();
    n = 0;
    while (write_busy !== 1'b0 && n < WCYC + 100) begin
      @(negedge clk);
      n++;
    end
    check(n < WCYC + 100, 1'b1);
    if (n >= WCYC + 100) begin
      report_and_stop();
    end
    check(standby, 1'b1);
    $display("test write done");
  endtask : t_write

  task automatic t_power();
    sel({ID, strap, 1'b1});
    check(ack, 1'b1);
    // Let the acknowledge finish so that power drops in the active state.
    settle(8);
    check(selected, 1'b1);
    por = 1'b1;
    settle(12);
    check({standby, selected}, 2'h2);
    stop_settle();
    sel({ID, strap, 1'b1});
    check(ack, 1'b0);
    check(sda_oe_b, 1'b1);
    stop_settle();
    por = 1'b0;
    settle(12);
    sel({ID, strap, 1'b1});
    check(ack, 1'b1);
    stop_settle();
    $display("test power done");
  endtask : t_power

  task automatic report_and_stop();
    $display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    #200000;
    n_mismatch++;
    report_and_stop();
  end

  initial begin
    rst_b = 1'b0;
    por = 1'b0;
    strap = 3'h5;
    cap = 2'h0;
    repeat (16) @(negedge clk);
    rst_b = 1'b1;
    settle(12);
    t_reset();
    t_capacity();
    t_mismatch();
    t_write();
    t_power();
    report_and_stop();
  end
endmodule : tb_seb_frontend
